// ---- dit_checker_sva.sv ----
// Purpose: Port checks for the dual interval timers.
// Assumes: One clock domain, synchronous active high reset.
// Notes: Bound to every instance of the top module.
`timescale 1ns/1ps
module dit_checker
	import dit_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Bus write answers, read requests and read answers.
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pins.
	input wire logic timer_one_wave_pin,
	input wire logic timer_one_wave_oe,
	input wire logic interrupt_request_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_irq_after_reset; $fell(rst) |-> interrupt_request_n; endproperty
	a_irq_after_reset: assert property (p_irq_after_reset) else $error("irq low after reset");
	property p_wave_idle; !timer_one_wave_oe |-> timer_one_wave_pin; endproperty
	a_wave_idle: assert property (p_wave_idle) else $error("wave pin low while undriven");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_r_answer: assert property (p_r_answer) else $error("read answer late");
	property p_r_byte; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
	a_r_byte: assert property (p_r_byte) else $error("upper read bits set");
	property p_r_refuse; s_axi_rvalid && s_axi_rresp == DIT_RESP_SLVERR |-> s_axi_rdata == 32'h00000000; endproperty
	a_r_refuse: assert property (p_r_refuse) else $error("refused read carries data");
	property p_bad_addr;
		s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'b00
		|=> s_axi_rresp == DIT_RESP_SLVERR && s_axi_rdata == 32'h00000000;
	endproperty
	a_bad_addr: assert property (p_bad_addr) else $error("unaligned read not refused");
endmodule // dit_checker

bind dit_top dit_checker #(.ADDR_W(ADDR_W)) chk (.*);

// ---- dit_pkg.sv ----
// Purpose: Shared constants for the dual interval timers block.
// Assumes: Register index times four gives the AXI4-Lite byte address.
// Notes: Reset values and field positions are named once here.
package dit_pkg;

	// ----------------------------------------------------------------
	// Register indices
	// ----------------------------------------------------------------
	localparam logic [5:0] DIT_IDX_TM1_CNT_LO = 6'h04;
	localparam logic [5:0] DIT_IDX_TM1_CNT_HI = 6'h05;
	localparam logic [5:0] DIT_IDX_TM1_LAT_LO = 6'h06;
	localparam logic [5:0] DIT_IDX_TM1_LAT_HI = 6'h07;
	localparam logic [5:0] DIT_IDX_TM2_CNT_LO = 6'h08;
	localparam logic [5:0] DIT_IDX_TM2_CNT_HI = 6'h09;
	localparam logic [5:0] DIT_IDX_AUX_CTRL = 6'h0b;
	localparam logic [5:0] DIT_IDX_INT_FLAG = 6'h0d;
	localparam logic [5:0] DIT_IDX_INT_ENA = 6'h0e;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int DIT_AUX_TM1_WAVE_BIT = 7;
	localparam int DIT_AUX_TM1_FREE_BIT = 6;
	localparam int DIT_AUX_TM2_MODE_BIT = 5;
	localparam int DIT_FLAG_ANY_BIT = 7;
	localparam int DIT_FLAG_TM1_BIT = 6;
	localparam int DIT_FLAG_TM2_BIT = 5;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] DIT_AUX_RST = 8'h00;
	localparam logic [7:0] DIT_ENA_RST = 8'h00;
	localparam logic [7:0] DIT_LATCH_RST = 8'h00;
	localparam logic [15:0] DIT_CNT_RST = 16'h0000;
	localparam logic DIT_WAVE_RST = 1'b1;

	// ----------------------------------------------------------------
	// Bus answers
	// ----------------------------------------------------------------
	localparam logic [1:0] DIT_RESP_OKAY = 2'h0;
	localparam logic [1:0] DIT_RESP_SLVERR = 2'h2;

endpackage

// ---- dit_pulse_src.sv ----
// Purpose: Far-side pulse source for the timer two pulse pin.
// Assumes: Pin idles high as if pulled up.
// Notes: Each fire request gives one four-cycle low pulse.
`timescale 1ns/1ps
module dit_pulse_src
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Request and pin.
	input wire logic fire,
	output logic pin
);
	logic [2:0] left_r;

	// Count down the low time of one negative pulse.
	always_ff @(posedge clk)
	begin
		if (rst)
			left_r <= 3'h0;
		else if (fire)
			left_r <= 3'h4;
		else if (left_r != 3'h0)
			left_r <= left_r - 3'h1;
	end

	// Low while a pulse is running, so the low level spans clock edges.
	assign pin = (left_r == 3'h0);
endmodule // dit_pulse_src

// ---- dit_top.sv ----
// Purpose: Two 16-bit down-counting interval timers behind AXI4-Lite.
// Assumes: One clock; ce low freezes every flip-flop and the bus.
// Notes: Registers hold eight bits in the low byte lane; upper bits read 0.
`timescale 1ns/1ps

module dit_top
	import dit_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	// Clock, reset and freeze.
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// AXI4-Lite write address and data.
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read.
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Port pins and interrupt.
	output logic timer_one_wave_pin,
	output logic timer_one_wave_oe,
	input wire logic timer_two_pulse_pin,
	output logic interrupt_request_n
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic aw_held_r;
	logic w_held_r;
	logic [ADDR_W-1:0] aw_addr_r;
	logic [7:0] w_byte_r;
	logic w_lane0_r;
	logic [1:0] bresp_r;
	logic bvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic rvalid_r;
	logic wr_fire;
	logic wr_go;
	logic [5:0] wr_idx;
	logic rd_fire;
	logic [5:0] rd_idx;
	logic [7:0] aux_control_r;
	logic [7:0] int_enable_r;
	logic [7:0] tm1_latch_lo_r;
	logic [7:0] tm1_latch_hi_r;
	logic [15:0] tm1_cnt_r;
	logic tm1_armed_r;
	logic tm1_flag_r;
	logic tm1_wave_r;
	logic [7:0] tm2_latch_lo_r;
	logic [15:0] tm2_cnt_r;
	logic tm2_armed_r;
	logic tm2_flag_r;
	logic t2p_meta_r;
	logic t2p_sync_r;
	logic t2p_prev_r;
	logic tm1_load;
	logic tm1_zero;
	logic tm1_free;
	logic tm1_set;
	logic tm1_clr;
	logic tm2_load;
	logic tm2_step;
	logic tm2_set;
	logic tm2_clr;
	logic flag_wr;
	logic [7:0] flag_view;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Only word-aligned addresses of listed registers are mapped.
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		logic [5:0] ix;
		ix = a[7:2];
		is_mapped = 1'b0;
		if (a[1:0] == 2'h0)
		begin
			case (ix)
				DIT_IDX_TM1_CNT_LO, DIT_IDX_TM1_CNT_HI,
				DIT_IDX_TM1_LAT_LO, DIT_IDX_TM1_LAT_HI,
				DIT_IDX_TM2_CNT_LO, DIT_IDX_TM2_CNT_HI,
				DIT_IDX_AUX_CTRL, DIT_IDX_INT_FLAG,
				DIT_IDX_INT_ENA: is_mapped = 1'b1;
				default: is_mapped = 1'b0;
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// AXI4-Lite handshakes
	// ----------------------------------------------------------------
	// Readies are held off while frozen so no item is lost.
	assign s_axi_awready = ce & ~aw_held_r;
	assign s_axi_wready = ce & ~w_held_r;
	assign s_axi_arready = ce & ~rvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;

	// A write completes once both halves are held and no answer waits.
	assign wr_fire = ce & aw_held_r & w_held_r & ~bvalid_r;
	assign wr_idx = aw_addr_r[7:2];
	assign wr_go = wr_fire & w_lane0_r & is_mapped(aw_addr_r);
	assign rd_fire = s_axi_arvalid & s_axi_arready;
	assign rd_idx = s_axi_araddr[7:2];

	// Write address and data are captured in either order.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= '0;
			w_byte_r <= 8'h00;
			w_lane0_r <= 1'b0;
		end
		else if (ce)
		begin
			if (s_axi_awvalid & s_axi_awready)
			begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			else if (wr_fire)
				aw_held_r <= 1'b0;
			if (s_axi_wvalid & s_axi_wready)
			begin
				w_held_r <= 1'b1;
				w_byte_r <= s_axi_wdata[7:0];
				w_lane0_r <= s_axi_wstrb[0];
			end
			else if (wr_fire)
				w_held_r <= 1'b0;
		end
	end

	// Write response; unmapped addresses answer SLVERR.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			bvalid_r <= 1'b0;
			bresp_r <= DIT_RESP_OKAY;
		end
		else if (ce)
		begin
			if (wr_fire)
			begin
				bvalid_r <= 1'b1;
				bresp_r <= is_mapped(aw_addr_r) ? DIT_RESP_OKAY : DIT_RESP_SLVERR;
			end
			else if (s_axi_bready)
				bvalid_r <= 1'b0;
		end
	end

	// Read data is sampled at the address handshake.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rvalid_r <= 1'b0;
			rresp_r <= DIT_RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end
		else if (ce)
		begin
			if (rd_fire)
			begin
				rvalid_r <= 1'b1;
				rresp_r <= is_mapped(s_axi_araddr) ? DIT_RESP_OKAY : DIT_RESP_SLVERR;
				case (s_axi_araddr[1:0] == 2'h0 ? rd_idx : 6'h00)
					DIT_IDX_TM1_CNT_LO: rdata_r <= {24'h0, tm1_cnt_r[7:0]};
					DIT_IDX_TM1_CNT_HI: rdata_r <= {24'h0, tm1_cnt_r[15:8]};
					DIT_IDX_TM1_LAT_LO: rdata_r <= {24'h0, tm1_latch_lo_r};
					DIT_IDX_TM1_LAT_HI: rdata_r <= {24'h0, tm1_cnt_r[15:8]};
					DIT_IDX_TM2_CNT_LO: rdata_r <= {24'h0, tm2_cnt_r[7:0]};
					DIT_IDX_TM2_CNT_HI: rdata_r <= {24'h0, tm2_cnt_r[15:8]};
					DIT_IDX_AUX_CTRL: rdata_r <= {24'h0, aux_control_r};
					DIT_IDX_INT_FLAG: rdata_r <= {24'h0, flag_view};
					DIT_IDX_INT_ENA: rdata_r <= {24'h0, int_enable_r};
					default: rdata_r <= 32'h0000_0000;
				endcase
			end
			else if (s_axi_rready)
				rvalid_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	// Auxiliary control selects modes; enable gates the request line.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			aux_control_r <= DIT_AUX_RST;
			int_enable_r <= DIT_ENA_RST;
		end
		else if (ce & wr_go)
		begin
			if (wr_idx == DIT_IDX_AUX_CTRL)
				aux_control_r <= w_byte_r;
			if (wr_idx == DIT_IDX_INT_ENA)
				int_enable_r <= w_byte_r;
		end
	end

	assign tm1_free = aux_control_r[DIT_AUX_TM1_FREE_BIT];
	assign timer_one_wave_oe = aux_control_r[DIT_AUX_TM1_WAVE_BIT];

	// ----------------------------------------------------------------
	// Timer one
	// ----------------------------------------------------------------
	// Low latch takes writes at either low index; high latch at either high index.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			tm1_latch_lo_r <= DIT_LATCH_RST;
			tm1_latch_hi_r <= DIT_LATCH_RST;
		end
		else if (ce & wr_go)
		begin
			if (wr_idx == DIT_IDX_TM1_CNT_LO || wr_idx == DIT_IDX_TM1_LAT_LO)
				tm1_latch_lo_r <= w_byte_r;
			if (wr_idx == DIT_IDX_TM1_CNT_HI || wr_idx == DIT_IDX_TM1_LAT_HI)
				tm1_latch_hi_r <= w_byte_r;
		end
	end

	assign tm1_load = wr_go & (wr_idx == DIT_IDX_TM1_CNT_HI);
	assign tm1_zero = (tm1_cnt_r == DIT_CNT_RST);

	// Loading restarts the count; decrementing begins on the next clock.
	always_ff @(posedge clk)
	begin
		if (rst)
			tm1_cnt_r <= DIT_CNT_RST;
		else if (ce)
		begin
			if (tm1_load)
				tm1_cnt_r <= {w_byte_r, tm1_latch_lo_r};
			else if (tm1_zero & tm1_free)
				tm1_cnt_r <= {tm1_latch_hi_r, tm1_latch_lo_r};
			else
				tm1_cnt_r <= tm1_cnt_r - 16'h0001;
		end
	end

	// One-shot arming allows a single flag per load.
	always_ff @(posedge clk)
	begin
		if (rst)
			tm1_armed_r <= 1'b0;
		else if (ce)
		begin
			if (tm1_load)
				tm1_armed_r <= 1'b1;
			else if (tm1_zero)
				tm1_armed_r <= 1'b0;
		end
	end

	// Flag set wins over any clear, a restarting load included, in the same cycle.
	assign tm1_set = tm1_zero & (tm1_free | tm1_armed_r);
	assign flag_wr = wr_go & (wr_idx == DIT_IDX_INT_FLAG);
	assign tm1_clr = (rd_fire & rd_idx == DIT_IDX_TM1_CNT_LO & s_axi_araddr[1:0] == 2'h0)
		| (wr_go & (wr_idx == DIT_IDX_TM1_CNT_HI || wr_idx == DIT_IDX_TM1_LAT_HI))
		| (flag_wr & w_byte_r[DIT_FLAG_TM1_BIT]);

	always_ff @(posedge clk)
	begin
		if (rst)
			tm1_flag_r <= 1'b0;
		else if (ce)
			tm1_flag_r <= tm1_set | (tm1_flag_r & ~tm1_clr);
	end

	// Wave output: low on load, high at one-shot end, toggled in free run.
	always_ff @(posedge clk)
	begin
		if (rst)
			tm1_wave_r <= DIT_WAVE_RST;
		else if (ce)
		begin
			if (tm1_load)
				tm1_wave_r <= 1'b0;
			else if (tm1_zero & tm1_free)
				tm1_wave_r <= ~tm1_wave_r;
			else if (tm1_zero & tm1_armed_r)
				tm1_wave_r <= 1'b1;
		end
	end

	// The pin idles high when the wave output is disabled.
	assign timer_one_wave_pin = timer_one_wave_oe ? tm1_wave_r : 1'b1;

	// ----------------------------------------------------------------
	// Timer two
	// ----------------------------------------------------------------
	// Pulse pin passes two flip-flops; the edge detector compares the second with a third, never the first.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			t2p_meta_r <= 1'b1;
			t2p_sync_r <= 1'b1;
			t2p_prev_r <= 1'b1;
		end
		else if (ce)
		begin
			t2p_meta_r <= timer_two_pulse_pin;
			t2p_sync_r <= t2p_meta_r;
			t2p_prev_r <= t2p_sync_r;
		end
	end

	// One step per clock, or per falling edge in pulse counting mode.
	assign tm2_step = aux_control_r[DIT_AUX_TM2_MODE_BIT] ? (t2p_prev_r & ~t2p_sync_r) : 1'b1;
	assign tm2_load = wr_go & (wr_idx == DIT_IDX_TM2_CNT_HI);

	// Low latch is write-only from the bus.
	always_ff @(posedge clk)
	begin
		if (rst)
			tm2_latch_lo_r <= DIT_LATCH_RST;
		else if (ce & wr_go & (wr_idx == DIT_IDX_TM2_CNT_LO))
			tm2_latch_lo_r <= w_byte_r;
	end

	// Counter loads from the high byte and low latch, then wraps freely.
	always_ff @(posedge clk)
	begin
		if (rst)
			tm2_cnt_r <= DIT_CNT_RST;
		else if (ce)
		begin
			if (tm2_load)
				tm2_cnt_r <= {w_byte_r, tm2_latch_lo_r};
			else if (tm2_step)
				tm2_cnt_r <= tm2_cnt_r - 16'h0001;
		end
	end

	// Arming allows one flag per reload of the high byte.
	always_ff @(posedge clk)
	begin
		if (rst)
			tm2_armed_r <= 1'b0;
		else if (ce)
		begin
			if (tm2_load)
				tm2_armed_r <= 1'b1;
			else if (tm2_set)
				tm2_armed_r <= 1'b0;
		end
	end

	// The timeout event wins over a clear or reload in the same cycle.
	assign tm2_set = tm2_step & tm2_armed_r & (tm2_cnt_r == DIT_CNT_RST);
	assign tm2_clr = (rd_fire & rd_idx == DIT_IDX_TM2_CNT_LO & s_axi_araddr[1:0] == 2'h0)
		| tm2_load | (flag_wr & w_byte_r[DIT_FLAG_TM2_BIT]);

	always_ff @(posedge clk)
	begin
		if (rst)
			tm2_flag_r <= 1'b0;
		else if (ce)
			tm2_flag_r <= tm2_set | (tm2_flag_r & ~tm2_clr);
	end

	// ----------------------------------------------------------------
	// Interrupt request
	// ----------------------------------------------------------------
	// Bit seven reads high while any enabled flag is active.
	always_comb
	begin
		flag_view = 8'h00;
		flag_view[DIT_FLAG_TM1_BIT] = tm1_flag_r;
		flag_view[DIT_FLAG_TM2_BIT] = tm2_flag_r;
		flag_view[DIT_FLAG_ANY_BIT] = (tm1_flag_r & int_enable_r[DIT_FLAG_TM1_BIT])
			| (tm2_flag_r & int_enable_r[DIT_FLAG_TM2_BIT]);
	end

	assign interrupt_request_n = ~flag_view[DIT_FLAG_ANY_BIT];

endmodule // dit_top

// ---- dual_interval_timers_bench.sv ----
// Purpose: Self-checking bench for the dual interval timers.
// Assumes: Host reaches registers by AXI4-Lite at 4 times the index.
// Notes: Timing expectations follow the load-to-flag figure of N+1 cycles.
`timescale 1ns/1ps
module dual_interval_timers_bench;
	import dit_pkg::*;
	localparam logic [7:0] ad_t1l = {DIT_IDX_TM1_CNT_LO, 2'b00};
	localparam logic [7:0] ad_t1h = {DIT_IDX_TM1_CNT_HI, 2'b00};
	localparam logic [7:0] ad_l1l = {DIT_IDX_TM1_LAT_LO, 2'b00};
	localparam logic [7:0] ad_l1h = {DIT_IDX_TM1_LAT_HI, 2'b00};
	localparam logic [7:0] ad_t2l = {DIT_IDX_TM2_CNT_LO, 2'b00};
	localparam logic [7:0] ad_t2h = {DIT_IDX_TM2_CNT_HI, 2'b00};
	localparam logic [7:0] ad_aux = {DIT_IDX_AUX_CTRL, 2'b00};
	localparam logic [7:0] ad_flg = {DIT_IDX_INT_FLAG, 2'b00};
	localparam logic [7:0] ad_ena = {DIT_IDX_INT_ENA, 2'b00};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [31:0] s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic timer_one_wave_pin, timer_one_wave_oe, timer_two_pulse_pin, interrupt_request_n;
	logic fire = 1'b0;
	logic [7:0] rv;
	int failures = 0;
	int checks_done = 0;

	// Free-running 200 MHz clock.
	always #2.5 clk = ~clk;

	dit_top uut (.*);
	dit_pulse_src far (.clk(clk), .rst(rst), .fire(fire), .pin(timer_two_pulse_pin));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tmo(input int n);
		if (n > 200)
		begin
			failures++;
			tally_and_finish();
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Write: address and data together, bready held until the answer is sampled.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			n++;
			tmo(n);
		end
		while (!s_axi_bvalid);
		rr = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	// Read: rready held until the answer is sampled.
	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			n++;
			tmo(n);
		end
		while (!s_axi_rvalid);
		rv = s_axi_rdata[7:0];
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic pulse;
		@(posedge clk) fire <= 1'b1;
		@(posedge clk) fire <= 1'b0;
		idle(12);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial
	begin
		idle(5);
		rst <= 1'b0;
		rd(ad_aux); chk(rv, DIT_AUX_RST);
		chk({6'h00, rr}, {6'h00, DIT_RESP_OKAY});
		rd(ad_ena); chk(rv, DIT_ENA_RST);
		chk({6'h00, timer_one_wave_oe, timer_one_wave_pin}, 8'h01);
		rd(8'h11); chk({6'h00, rr}, {6'h00, DIT_RESP_SLVERR});
		wr(8'h11, 8'h55); chk({6'h00, rr}, {6'h00, DIT_RESP_SLVERR});
		// One-shot with pulse output, period 0x31 cycles.
		wr(ad_ena, 8'h60); chk({6'h00, rr}, {6'h00, DIT_RESP_OKAY});
		wr(ad_aux, 8'h80);
		wr(ad_t1l, 8'h30);
		wr(ad_t1h, 8'h00);
		chk({7'h00, timer_one_wave_pin}, 8'h00);
		rd(ad_flg); chk(rv, 8'h00);
		rd(ad_l1l); chk(rv, 8'h30);
		idle(60);
		chk({7'h00, timer_one_wave_pin}, 8'h01);
		chk({7'h00, interrupt_request_n}, 8'h00);
		rd(ad_l1l); rd(ad_flg); chk(rv, 8'hc0);
		rd(ad_t1l); rd(ad_flg); chk(rv, 8'h00);
		idle(60); rd(ad_flg); chk(rv, 8'h00);
		// Reloads before zero keep the timeout away.
		wr(ad_t1h, 8'h00);
		repeat (3)
		begin
			idle(30);
			wr(ad_t1h, 8'h00);
		end
		rd(ad_flg); chk(rv, 8'h00);
		idle(60);
		wr(ad_l1h, 8'h00); rd(ad_flg); chk(rv, 8'h00);
		rd(ad_t1h); chk(rv, 8'hff);
		// Free-run square wave, latch changed during the first period.
		wr(ad_aux, 8'hc0);
		wr(ad_t1l, 8'h20);
		wr(ad_t1h, 8'h00);
		wr(ad_l1l, 8'h40);
		idle(40);
		rd(ad_flg); chk(rv, 8'hc0);
		chk({7'h00, timer_one_wave_pin}, 8'h01);
		wr(ad_flg, 8'h40); rd(ad_flg); chk(rv, 8'h00);
		idle(55);
		rd(ad_flg); chk(rv, 8'hc0);
		chk({7'h00, timer_one_wave_pin}, 8'h00);
		// Continuous interrupts with the wave pin released.
		wr(ad_aux, 8'h40);
		chk({6'h00, timer_one_wave_oe, timer_one_wave_pin}, 8'h01);
		// Timer two interval mode, frozen for a while by the clock enable.
		wr(ad_aux, 8'h00);
		wr(ad_t2l, 8'h10);
		wr(ad_t2h, 8'h00);
		rd(ad_flg); chk(rv & 8'h20, 8'h00);
		@(posedge clk) ce <= 1'b0;
		idle(40);
		@(posedge clk) ce <= 1'b1;
		rd(ad_flg); chk(rv & 8'h20, 8'h00);
		idle(30);
		rd(ad_flg); chk(rv & 8'h20, 8'h20);
		rd(ad_t2h); chk(rv, 8'hff);
		rd(ad_t2l); rd(ad_flg); chk(rv & 8'h20, 8'h00);
		// Timer two pulse counting from two.
		wr(ad_aux, 8'h20);
		wr(ad_t2l, 8'h02);
		wr(ad_t2h, 8'h00);
		idle(20);
		rd(ad_flg); chk(rv & 8'h20, 8'h00);
		pulse();
		pulse();
		rd(ad_t2l); chk(rv, 8'h00);
		pulse();
		rd(ad_flg); chk(rv & 8'h20, 8'h20);
		wr(ad_flg, 8'h20); rd(ad_flg); chk(rv & 8'h20, 8'h00);
		tally_and_finish();
	end

	// Cut a hang short.
	initial
	begin
		#400000;
		failures++;
		tally_and_finish();
	end
endmodule // dual_interval_timers_bench
